// ==== design/pstm_pkg.sv ====
package pstm_pkg;

    // Clock and timing
    localparam int  MCLK_HZ          = 10_000_000;
    localparam int  EE_WRITE_MS      = 5;
    localparam int  SCL_TIMEOUT_MS   = 25;
    localparam int  EE_WRITE_CYC     = MCLK_HZ / 1000 * EE_WRITE_MS;
    localparam int  SCL_TIMEOUT_CYC  = MCLK_HZ / 1000 * SCL_TIMEOUT_MS + 1;

    // Target addresses, 8-bit form with R/W in bit 0
    localparam logic [7:0] CTRL_ADDR_BASE = 8'hb0;
    localparam logic [7:0] EE_ADDR_BASE   = 8'ha0;

    // Command codes
    localparam logic [7:0] CMD_RECT_TEMP  = 8'h8d;
    localparam logic [7:0] CMD_INLET_TEMP = 8'h8e;
    localparam logic [7:0] CMD_TEMP2      = 8'hd0;
    localparam logic [7:0] CMD_TEMP3      = 8'hd1;
    localparam logic [7:0] CMD_TEMP4      = 8'hd2;
    localparam logic [7:0] CMD_TEMP5      = 8'hd3;
    localparam logic [7:0] CMD_FAN_MIN    = 8'hd8;
    localparam logic [7:0] CMD_BLOCK_WR   = 8'hd9;
    localparam logic [7:0] CMD_BLOCK_TEMP = 8'hda;
    localparam logic [7:0] BLOCK_TEMP_LEN = 8'h0c;
    localparam logic [8:0] MAX_XFER_BYTES = 9'h0ff;
    localparam logic [7:0] FILL_BYTE      = 8'hff;

    // Sensors: 0 inlet air, 1 rectifier, 5 auxiliary converter
    localparam int  NUM_SENSORS = 6;
    localparam int  SNS_INLET   = 0;
    localparam int  SNS_RECT    = 1;
    localparam int  SNS_AUX     = 5;
    localparam logic [5:0][15:0] WARN_DEGC = {
        16'h0064, 16'h005f, 16'h005f, 16'h005f, 16'h0052, 16'h0039};
    localparam logic [5:0][15:0] SHUT_DEGC = {
        16'h0069, 16'h0064, 16'h0064, 16'h0064, 16'h0055, 16'h003c};

    // Fan curve
    localparam logic [7:0] FAN_MAX        = 8'hff;
    localparam logic [7:0] FAN_INLET_BASE = 8'h14;
    localparam logic [9:0] FAN_FLOOR      = 10'h040;

    typedef logic [5:0][15:0] pstm_temps_t;

    // Pins sampled together through the synchroniser
    typedef struct packed {
        logic scl;
        logic sda;
        logic sel1;
        logic sel0;
    } pstm_pins_t;

    typedef enum logic [1:0] {
        LED_OK,
        LED_WARN_BLINK,
        LED_FAULT_SOLID
    } pstm_led_t;

endpackage

// ==== design/pstm_target.sv ====
// Overview of operation
// - Controller and EEPROM answer separate addresses only
// - EEPROM holds 256 user bytes, unused internally
// - Write Byte stores data at given location
// - Read Byte returns byte at set location
// - Clock stretch never exceeds 1 ms
// - SCL low over 25 ms aborts transfer
// - START/STOP detected anywhere, state resynchronised
// - Controller bytes are command codes, not addresses
// - Controller writes end after 0, 1, 2 or more data
// - Controller reads return byte or word
// - Block write and read up to 255 bytes
// - Six sensors measured and readable over bus
// - Fan speed follows output power and inlet
// - Any warning forces fan to maximum
// - Shutdown disables main, or standby for auxiliary
// - Events shown on LED, power good, alert
// - Inlet sensor warns 57, shuts down 60
// - Rectifier sensor warns 82, shuts down 85
// - Addresses are base plus twice select pins
// - Open select pins read high
// - Alert low while any warning or shutdown
`timescale 1ns/1ns
`default_nettype none

module pstm_target #(
    parameter int EE_WRITE_CYCLES   = pstm_pkg::EE_WRITE_CYC,
    parameter int SCL_TIMEOUT_CYCLES = pstm_pkg::SCL_TIMEOUT_CYC
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    input  wire logic                 i_scl,
    output logic                      o_scl,
    output logic                      o_scl_oe_n,
    input  wire logic                 i_sda,
    output logic                      o_sda,
    output logic                      o_sda_oe_n,
    input  wire logic                 i_addr_select_bit0,
    input  wire logic                 i_addr_select_bit1,
    input  wire pstm_pkg::pstm_temps_t i_sensor_temp,
    input  wire logic [15:0]          i_output_power,
    output logic [7:0]                o_fan_speed,
    output logic                      o_main_output_rail,
    output logic                      o_standby_output_rail,
    output logic                      o_power_good_output,
    output logic                      o_alert_output_low,
    output pstm_pkg::pstm_led_t       o_led_state
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_WBYTE, ST_RBYTE, ST_MACK
    } pstm_state_t;
    // Three-stage pin sampler; a bit moves once stages 2 and 3 agree
    pstm_pkg::pstm_pins_t s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            {s1_reg, s2_reg, s3_reg, filt_reg, prev_reg} <= '1;
        end else begin
            s1_reg   <= {i_scl, i_sda, i_addr_select_bit1, i_addr_select_bit0};
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
            prev_reg <= filt_reg;
        end
    end

    // Bus events
    wire scl_rise = filt_reg.scl & ~prev_reg.scl;
    wire scl_fall = ~filt_reg.scl & prev_reg.scl;
    wire scl_hi   = filt_reg.scl & prev_reg.scl;
    wire start_ev = scl_hi & prev_reg.sda & ~filt_reg.sda;
    wire stop_ev  = scl_hi & ~prev_reg.sda & filt_reg.sda;

    // Address match; open pins pull high so default is top address
    wire [7:0] sel_ofs    = {5'h00, filt_reg.sel1, filt_reg.sel0, 1'b0};
    wire [7:0] ctrl_addr  = pstm_pkg::CTRL_ADDR_BASE + sel_ofs;
    wire [7:0] ee_addr    = pstm_pkg::EE_ADDR_BASE + sel_ofs;

    pstm_state_t  state_reg;
    logic [7:0]   shift_reg, tx_reg, cmd_reg, ptr_reg, fan_min_reg;
    logic [3:0]   bit_cnt_reg;
    logic [8:0]   byte_idx_reg, rd_idx_reg;
    logic         ee_sel_reg, rd_reg, sda_low_reg, nack_reg, dirty_reg;
    logic [31:0]  busy_cnt_reg, tout_cnt_reg;
    logic [7:0]   ee_mem [0:255];

    wire ee_busy   = busy_cnt_reg != 32'h0;
    wire hit_ctrl  = shift_reg[7:1] == ctrl_addr[7:1];
    wire hit_ee    = (shift_reg[7:1] == ee_addr[7:1]) & ~ee_busy;
    wire byte_done = scl_fall & (bit_cnt_reg == 4'h8);
    wire timeout   = tout_cnt_reg >= 32'(SCL_TIMEOUT_CYCLES);
    wire too_long  = byte_idx_reg >= pstm_pkg::MAX_XFER_BYTES;

    // Sensor bytes for block reads, low byte of each word first
    wire [3:0] blk_sel   = 4'(rd_idx_reg - 9'h001);
    wire [2:0] blk_sns   = blk_sel[3:1];
    wire [15:0] blk_word = (blk_sns < 3'(pstm_pkg::NUM_SENSORS)) ?
                           i_sensor_temp[blk_sns] : 16'hffff;
    wire [7:0] blk_byte  = blk_sel[0] ? blk_word[15:8] : blk_word[7:0];

    // Command decode: codes pick a value, not a memory slot
    logic [15:0] cmd_word;
    logic        cmd_is_word;
    always_comb begin
        cmd_word    = {pstm_pkg::FILL_BYTE, pstm_pkg::FILL_BYTE};
        cmd_is_word = 1'b1;
        if (cmd_reg == pstm_pkg::CMD_INLET_TEMP) begin
            cmd_word = i_sensor_temp[pstm_pkg::SNS_INLET];
        end else if (cmd_reg == pstm_pkg::CMD_RECT_TEMP) begin
            cmd_word = i_sensor_temp[pstm_pkg::SNS_RECT];
        end else if (cmd_reg[7:2] == pstm_pkg::CMD_TEMP2[7:2]) begin
            cmd_word = i_sensor_temp[{1'b0, cmd_reg[1:0]} + 3'h2];
        end else if (cmd_reg == pstm_pkg::CMD_FAN_MIN) begin
            cmd_word = {8'h00, fan_min_reg};
        end else begin
            cmd_is_word = 1'b0;
        end
    end

    // Next byte to send; a word gives low byte first
    wire is_blk = cmd_reg == pstm_pkg::CMD_BLOCK_TEMP;
    wire [7:0] ctrl_byte =
        is_blk ? ((rd_idx_reg == 9'h000) ? pstm_pkg::BLOCK_TEMP_LEN :
                  (rd_idx_reg <= 9'(pstm_pkg::BLOCK_TEMP_LEN)) ? blk_byte :
                  pstm_pkg::FILL_BYTE) :
        (cmd_is_word & (rd_idx_reg == 9'h000)) ? cmd_word[7:0] :
        (cmd_is_word & (rd_idx_reg == 9'h001)) ? cmd_word[15:8] :
        pstm_pkg::FILL_BYTE;
    wire [7:0] rd_byte = ee_sel_reg ? ee_mem[ptr_reg] : ctrl_byte;

    // Transfer sequencer; stretching is never used, SCL is only read
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            {shift_reg, tx_reg, bit_cnt_reg, byte_idx_reg, rd_idx_reg} <= '0;
            {ee_sel_reg, rd_reg, sda_low_reg, nack_reg} <= '0;
        end else if (start_ev) begin
            state_reg    <= ST_ADDR;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= 9'h000;
            rd_idx_reg   <= 9'h000;
            sda_low_reg  <= 1'b0;
        end else if (stop_ev | timeout) begin
            state_reg   <= ST_IDLE;
            sda_low_reg <= 1'b0;
        end else begin
            if (scl_rise && state_reg != ST_IDLE) begin
                shift_reg   <= {shift_reg[6:0], filt_reg.sda};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (state_reg == ST_MACK) begin
                    nack_reg <= filt_reg.sda;
                end
            end
            case (state_reg)
                ST_ADDR: begin
                    if (byte_done) begin
                        ee_sel_reg  <= hit_ee;
                        rd_reg      <= shift_reg[0];
                        sda_low_reg <= hit_ctrl | hit_ee;
                        state_reg   <= (hit_ctrl | hit_ee) ? ST_ACK : ST_IDLE;
                    end
                end
                ST_WBYTE: begin
                    if (byte_done) begin
                        byte_idx_reg <= byte_idx_reg + 9'h001;
                        sda_low_reg  <= ~too_long;
                        state_reg    <= too_long ? ST_IDLE : ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (rd_reg) begin
                            tx_reg      <= {rd_byte[6:0], 1'b0};
                            sda_low_reg <= ~rd_byte[7];
                            state_reg   <= ST_RBYTE;
                        end else begin
                            sda_low_reg <= 1'b0;
                            state_reg   <= ST_WBYTE;
                        end
                    end
                end
                ST_RBYTE: begin
                    if (byte_done) begin
                        sda_low_reg <= 1'b0;
                        rd_idx_reg  <= rd_idx_reg + 9'h001;
                        state_reg   <= ST_MACK;
                    end else if (scl_fall) begin
                        sda_low_reg <= ~tx_reg[7];
                        tx_reg      <= {tx_reg[6:0], 1'b0};
                    end
                end
                ST_MACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (nack_reg) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            tx_reg      <= {rd_byte[6:0], 1'b0};
                            sda_low_reg <= ~rd_byte[7];
                            state_reg   <= ST_RBYTE;
                        end
                    end
                end
                default: begin
                    sda_low_reg <= 1'b0;
                end
            endcase
        end
    end

    // Write bytes: pointer or command first, then data
    wire wr_byte = ~start_ev & ~stop_ev & ~timeout & byte_done
                   & (state_reg == ST_WBYTE) & ~too_long;
    wire ee_data = wr_byte & ee_sel_reg & (byte_idx_reg != 9'h000);
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            {cmd_reg, ptr_reg, fan_min_reg} <= '0;
        end else begin
            if (wr_byte & (byte_idx_reg == 9'h000)) begin
                if (ee_sel_reg) begin
                    ptr_reg <= shift_reg;
                end else begin
                    cmd_reg <= shift_reg;
                end
            end else if (ee_data) begin
                ptr_reg <= ptr_reg + 8'h01;
            end else if (wr_byte & ~ee_sel_reg & (byte_idx_reg == 9'h001)
                         & (cmd_reg == pstm_pkg::CMD_FAN_MIN)) begin
                fan_min_reg <= shift_reg;
            end
            // Pointer advances per byte sent, as a plain serial EEPROM does
            if (~start_ev & ~stop_ev & byte_done & ee_sel_reg
                & (state_reg == ST_RBYTE)) begin
                ptr_reg <= ptr_reg + 8'h01;
            end
        end
    end

    // EEPROM array has no reset; contents are user data only
    always_ff @(posedge i_mclk) begin
        if (ee_data) begin
            ee_mem[ptr_reg] <= shift_reg;
        end
    end

    // Internal programming time, started by the STOP after data
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            {dirty_reg, busy_cnt_reg, tout_cnt_reg} <= '0;
        end else begin
            if (ee_data) begin
                dirty_reg <= 1'b1;
            end else if (stop_ev) begin
                dirty_reg <= 1'b0;
            end
            if (stop_ev & dirty_reg) begin
                busy_cnt_reg <= 32'(EE_WRITE_CYCLES);
            end else if (ee_busy) begin
                busy_cnt_reg <= busy_cnt_reg - 32'h1;
            end
            if (state_reg == ST_IDLE || filt_reg.scl) begin
                tout_cnt_reg <= 32'h0;
            end else if (~timeout) begin
                tout_cnt_reg <= tout_cnt_reg + 32'h1;
            end
        end
    end

    // Per-sensor comparisons, each one on its own
    logic [5:0] warn_vec, shut_vec;
    genvar gi;
    generate
        for (gi = 0; gi < pstm_pkg::NUM_SENSORS; gi++) begin : g_sns
            assign warn_vec[gi] = i_sensor_temp[gi]
                                  >= pstm_pkg::WARN_DEGC[gi];
            assign shut_vec[gi] = i_sensor_temp[gi]
                                  > pstm_pkg::SHUT_DEGC[gi];
        end
    endgenerate

    wire any_warn = |warn_vec;
    wire any_shut = |shut_vec;
    wire aux_shut = shut_vec[pstm_pkg::SNS_AUX];
    wire main_shut = |(shut_vec & ~(6'h01 << pstm_pkg::SNS_AUX));

    // Fan curve: power high byte plus scaled inlet excess, saturated
    wire [15:0] inlet = i_sensor_temp[pstm_pkg::SNS_INLET];
    wire [9:0]  inlet_ex = (inlet > 16'(pstm_pkg::FAN_INLET_BASE)) ?
                10'(inlet - 16'(pstm_pkg::FAN_INLET_BASE)) : 10'h000;
    wire [11:0] fan_sum = 12'(pstm_pkg::FAN_FLOOR) + 12'(i_output_power[15:8])
                          + {inlet_ex, 2'b00};
    wire [7:0]  fan_auto = (fan_sum > 12'(pstm_pkg::FAN_MAX)) ?
                           pstm_pkg::FAN_MAX : fan_sum[7:0];
    wire [7:0]  fan_next = any_warn ? pstm_pkg::FAN_MAX :
                (fan_auto > fan_min_reg) ? fan_auto : fan_min_reg;

    // Protection outputs registered so the pins never glitch
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_fan_speed           <= pstm_pkg::FAN_MAX;
            o_main_output_rail    <= 1'b0;
            o_standby_output_rail <= 1'b0;
            o_power_good_output   <= 1'b0;
            o_alert_output_low    <= 1'b1;
            o_led_state           <= pstm_pkg::LED_OK;
        end else begin
            o_fan_speed           <= fan_next;
            o_main_output_rail    <= ~main_shut;
            o_standby_output_rail <= ~aux_shut;
            o_power_good_output   <= ~any_shut;
            o_alert_output_low    <= ~(any_warn | any_shut);
            o_led_state <= any_shut ? pstm_pkg::LED_FAULT_SOLID :
                           any_warn ? pstm_pkg::LED_WARN_BLINK :
                           pstm_pkg::LED_OK;
        end
    end

    // Open-drain pins: only ever pull low, SCL is never held
    assign o_scl      = 1'b0;
    assign o_scl_oe_n = 1'b1;
    assign o_sda      = 1'b0;
    assign o_sda_oe_n = ~sda_low_reg;

endmodule

`default_nettype wire

// ==== verif/pstm_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module pstm_assertions #(
    parameter int SCL_TIMEOUT_CYCLES = 300
) (
    input wire logic                  i_mclk,
    input wire logic                  i_rst,
    input wire logic                  i_scl,
    input wire logic                  o_scl_oe_n,
    input wire logic                  o_sda,
    input wire logic                  o_sda_oe_n,
    input wire pstm_pkg::pstm_temps_t i_sensor_temp,
    input wire logic [7:0]            o_fan_speed,
    input wire logic                  o_main_output_rail,
    input wire logic                  o_standby_output_rail,
    input wire logic                  o_power_good_output,
    input wire logic                  o_alert_output_low,
    input wire pstm_pkg::pstm_led_t   o_led_state
);
    logic [5:0] warn;
    logic [5:0] shut;
    logic [1:0] live_reg;
    int         low_reg;
    wire        live = (live_reg == 2'h3);
    wire        any_w = |warn;
    wire        any_s = |shut;
    wire        shut_main = |shut[4:0];
    // Each sensor against its own pair of limits
    for (genvar i = 0; i < 6; i++) begin : g_cmp
        assign warn[i] = i_sensor_temp[i] >= pstm_pkg::WARN_DEGC[i];
        assign shut[i] = i_sensor_temp[i] > pstm_pkg::SHUT_DEGC[i];
    end
    // Outputs show reset values at first, so wait three edges before checking
    always_ff @(posedge i_mclk) begin
        if (i_rst) live_reg <= 2'h0;
        else if (!live) live_reg <= live_reg + 2'h1;
    end
    // Length of the current SCL low phase, saturating
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_scl) low_reg <= 0;
        else if (low_reg < SCL_TIMEOUT_CYCLES + 8) low_reg <= low_reg + 1;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_alert_set: assert property (
        live && (any_w || any_s) |=> !o_alert_output_low)
        else $error("alert output not low on event");
    a_alert_clear: assert property (
        live && !(any_w || any_s) |=> o_alert_output_low)
        else $error("alert output low without event");
    a_fan_max: assert property (
        live && any_w |=> o_fan_speed == pstm_pkg::FAN_MAX)
        else $error("fan not at maximum on warning");
    a_main_rail: assert property (
        live |=> o_main_output_rail == !$past(shut_main))
        else $error("main rail state wrong");
    a_standby_rail: assert property (
        live |=> o_standby_output_rail == !$past(shut[5]))
        else $error("standby rail state wrong");
    a_power_good: assert property (
        live |=> o_power_good_output == !$past(any_s))
        else $error("power good state wrong");
    a_led_fault: assert property (
        live && any_s |=> o_led_state == pstm_pkg::LED_FAULT_SOLID)
        else $error("led not solid on shutdown");
    a_led_warn: assert property (
        live && any_w && !any_s |=> o_led_state == pstm_pkg::LED_WARN_BLINK)
        else $error("led not blinking on warning");
    a_no_stretch: assert property (
        o_scl_oe_n && !o_sda)
        else $error("clock line driven");
    a_timeout_free: assert property (
        low_reg >= SCL_TIMEOUT_CYCLES + 8 |-> o_sda_oe_n)
        else $error("data line held after clock timeout");
    a_sda_on_low: assert property (
        $changed(o_sda_oe_n) |-> !i_scl)
        else $error("data line changed while clock high");
endmodule
bind pstm_target pstm_assertions #(
    .SCL_TIMEOUT_CYCLES(SCL_TIMEOUT_CYCLES)
) pstm_assertions_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(i_scl),
    .o_scl_oe_n(o_scl_oe_n), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
    .i_sensor_temp(i_sensor_temp), .o_fan_speed(o_fan_speed),
    .o_main_output_rail(o_main_output_rail),
    .o_standby_output_rail(o_standby_output_rail),
    .o_power_good_output(o_power_good_output),
    .o_alert_output_low(o_alert_output_low), .o_led_state(o_led_state)
);
`default_nettype wire

// ==== verif/pstm_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module pstm_host #(
    parameter int Q = 25
) (
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output logic      o_scl_low,
    output logic      o_sda_low
);
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    // Every line change is followed by a quarter bit
    task automatic scl(input logic v);
        @(posedge i_mclk);
        o_scl_low <= !v;
        repeat (Q - 1) @(posedge i_mclk);
    endtask
    task automatic sda(input logic v);
        @(posedge i_mclk);
        o_sda_low <= !v;
        repeat (Q - 1) @(posedge i_mclk);
    endtask
    // Start or repeated start, legal mid-byte as well
    task automatic start();
        sda(1'b1);
        scl(1'b1);
        sda(1'b0);
        scl(1'b0);
    endtask
    task automatic stop();
        sda(1'b0);
        scl(1'b1);
        sda(1'b1);
    endtask
    // Data set while clock low, sampled one cycle before the clock falls
    task automatic bit_x(input logic d, output logic r);
        sda(d);
        scl(1'b1);
        repeat (Q) @(posedge i_mclk);
        r = i_sda;
        scl(1'b0);
    endtask
    // MSB first; the ack phase only follows a whole byte
    task automatic wbits(input logic [7:0] d, input int n, output logic ack);
        logic r;
        ack = 1'b1;
        for (int i = 0; i < n; i++) bit_x(d[7 - i], r);
        if (n == 8) bit_x(1'b1, ack);
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) bit_x(1'b1, d[7 - i]);
        bit_x(nack, r);
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_psu_smbus_target_thermal_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_psu_smbus_target_thermal_monitor;
    localparam int EE_CYC = 2000;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic sel0, sel1, scl_low, sda_low, d_scl, d_scl_oe_n, d_sda;
    logic d_sda_oe_n, main_on, stby_on, pwok, alert_n, a;
    logic [7:0] fan, ctrl, ee, fm, b;
    logic [7:0] mem [0:255];
    logic [15:0] pwr = 16'h0000;
    pstm_pkg::pstm_temps_t temps = '0, tv;
    pstm_pkg::pstm_led_t led;
    logic [7:0] q [$];
    int errors = 0, n_checks = 0, seed = 8354;
    int ci [12] = '{0, 0, 0, 0, 1, 1, 1, 1, 5, 5, 2, 2};
    int ct [12] = '{56, 57, 60, 61, 81, 82, 85, 86, 105, 106, 100, 101};
    // Open-drain wires with pull-ups: low if any party pulls
    wire scl_w = !scl_low && (d_scl_oe_n || d_scl);
    wire sda_w = !sda_low && (d_sda_oe_n || d_sda);
    always #50 i_mclk = ~i_mclk;
    pstm_host pstm_host_inst (.i_mclk(i_mclk), .i_sda(sda_w),
        .o_scl_low(scl_low), .o_sda_low(sda_low));
    pstm_target #(.EE_WRITE_CYCLES(EE_CYC), .SCL_TIMEOUT_CYCLES(300))
    pstm_target_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl_w),
        .o_scl(d_scl), .o_scl_oe_n(d_scl_oe_n), .i_sda(sda_w),
        .o_sda(d_sda), .o_sda_oe_n(d_sda_oe_n),
        .i_addr_select_bit0(sel0), .i_addr_select_bit1(sel1),
        .i_sensor_temp(temps), .i_output_power(pwr), .o_fan_speed(fan),
        .o_main_output_rail(main_on), .o_standby_output_rail(stby_on),
        .o_power_good_output(pwok), .o_alert_output_low(alert_n),
        .o_led_state(led));
    task automatic finish_test();
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] d, input logic exp);
        logic k;
        pstm_host_inst.wbits(d, 8, k);
        check({15'h0, k}, {15'h0, exp});
    endtask
    task automatic get(input logic [7:0] exp, input logic last);
        logic [7:0] d;
        pstm_host_inst.rbyte(last, d);
        check({8'h0, d}, {8'h0, exp});
    endtask
    task automatic rd_open(input logic [7:0] ad, input logic [7:0] c);
        pstm_host_inst.start();
        put(ad, 1'b0);
        put(c, 1'b0);
        pstm_host_inst.start();
        put(ad | 8'h01, 1'b0);
    endtask
    task automatic rd_word(input logic [7:0] c, input logic [15:0] exp);
        rd_open(ctrl, c);
        get(exp[7:0], 1'b0);
        get(exp[15:8], 1'b1);
        pstm_host_inst.stop();
    endtask
    // Reference for the monitor outputs from the temperature limits
    task automatic chk_thermal();
        int f;
        logic [5:0] w, s;
        pstm_pkg::pstm_led_t el;
        for (int i = 0; i < 6; i++) begin
            w[i] = temps[i] >= pstm_pkg::WARN_DEGC[i];
            s[i] = temps[i] > pstm_pkg::SHUT_DEGC[i];
        end
        f = int'(temps[0]) - int'(pstm_pkg::FAN_INLET_BASE);
        f = int'(pstm_pkg::FAN_FLOOR) + int'(pwr[15:8]) + (f > 0 ? 4 * f : 0);
        f = (f > 255) ? 255 : (f < int'(fm) ? int'(fm) : f);
        if (|w) f = 255;
        el = |s ? pstm_pkg::LED_FAULT_SOLID
            : (|w ? pstm_pkg::LED_WARN_BLINK : pstm_pkg::LED_OK);
        check({d_scl, d_sda, fan, main_on, stby_on, pwok, alert_n, led}, {2'h0,
            f[7:0], !(|s[4:0]), !s[5], !(|s), !(|w || |s),
            el});
    endtask
    initial begin
        repeat (100000) @(posedge i_mclk);
        errors++;
        finish_test();
    end
    initial begin
        {sel1, sel0} = 2'($random(seed));
        ctrl = pstm_pkg::CTRL_ADDR_BASE + {5'h0, sel1, sel0, 1'b0};
        ee = pstm_pkg::EE_ADDR_BASE + {5'h0, sel1, sel0, 1'b0};
        repeat (12) @(posedge i_mclk);
        check({d_sda_oe_n, d_scl_oe_n, fan, main_on, stby_on, pwok, alert_n,
            led}, {2'h3, 8'hff, 4'h1, pstm_pkg::LED_OK});
        i_rst <= 1'b0;
        repeat (8) @(posedge i_mclk);
        // Foreign addresses are refused
        pstm_host_inst.start();
        put(ctrl ^ 8'h02, 1'b1);
        pstm_host_inst.start();
        put(8'hc0, 1'b1);
        pstm_host_inst.stop();
        // Byte write of the fan floor, read back as a word
        fm = 8'($random(seed));
        pstm_host_inst.start();
        put(ctrl, 1'b0);
        put(pstm_pkg::CMD_FAN_MIN, 1'b0);
        put(fm, 1'b0);
        pstm_host_inst.stop();
        rd_word(pstm_pkg::CMD_FAN_MIN, {8'h00, fm});
        // Send-byte, word and block forms of one write command
        for (int n = 0; n < 6; n += 2) begin
            pstm_host_inst.start();
            put(ctrl, 1'b0);
            put(pstm_pkg::CMD_BLOCK_WR, 1'b0);
            for (int i = 0; i < n; i++) put(8'($random(seed)), 1'b0);
            pstm_host_inst.stop();
        end
        // Sensor words, an unknown command and the block read
        for (int i = 0; i < 6; i++) tv[i] = 16'(20 + ($random(seed) & 31));
        @(posedge i_mclk);
        temps <= tv;
        rd_word(pstm_pkg::CMD_RECT_TEMP, tv[1]);
        rd_word(pstm_pkg::CMD_INLET_TEMP, tv[0]);
        rd_word(8'h00, 16'hffff);
        q.push_back(pstm_pkg::BLOCK_TEMP_LEN);
        for (int i = 0; i < 6; i++) q.push_back(tv[i][7:0]);
        for (int i = 0; i < 6; i++) q.insert(2 * i + 2, tv[i][15:8]);
        rd_open(ctrl, pstm_pkg::CMD_BLOCK_TEMP);
        while (q.size() > 0) begin
            b = q.pop_front();
            get(b, q.size() == 0);
        end
        pstm_host_inst.stop();
        // Memory bytes, last location, and a start during programming
        for (int k = 0; k < 2; k++) begin
            b = (k == 1) ? 8'hff : 8'($random(seed));
            mem[b] = 8'($random(seed));
            pstm_host_inst.start();
            put(ee, 1'b0);
            put(b, 1'b0);
            put(mem[b], 1'b0);
            pstm_host_inst.stop();
            if (k == 1) begin
                pstm_host_inst.start();
                put(ee, 1'b1);
                pstm_host_inst.stop();
            end
            repeat (EE_CYC + 100) @(posedge i_mclk);
            rd_open(ee, b);
            get(mem[b], 1'b1);
            pstm_host_inst.stop();
        end
        // Stop and start cut into bytes
        pstm_host_inst.start();
        put(ee, 1'b0);
        pstm_host_inst.wbits(8'h5a, 3, a);
        pstm_host_inst.stop();
        pstm_host_inst.start();
        pstm_host_inst.wbits(ctrl, 4, a);
        rd_word(pstm_pkg::CMD_INLET_TEMP, tv[0]);
        // Clock held low past the timeout, then bits with no start
        pstm_host_inst.start();
        put(ctrl, 1'b0);
        repeat (400) @(posedge i_mclk);
        pstm_host_inst.wbits(ctrl, 8, a);
        check({15'h0, a}, 16'h0001);
        pstm_host_inst.stop();
        rd_word(pstm_pkg::CMD_RECT_TEMP, tv[1]);
        // Threshold edges for sensors 0, 1, 5 and 2 with random power and others
        for (int k = 0; k < 12; k++) begin
            for (int i = 0; i < 6; i++) tv[i] = 16'(20 + ($random(seed) & 31));
            tv[ci[k]] = 16'(ct[k]);
            @(posedge i_mclk);
            temps <= tv;
            pwr <= 16'($random(seed));
            repeat (3) @(posedge i_mclk);
            chk_thermal();
        end
        finish_test();
    end
endmodule
`default_nettype wire
